// ---- hw/ivsf_cfg.svh ----
`ifndef IVSF_CFG_SVH
`define IVSF_CFG_SVH

// special-function register addresses
`define IVSF_ADDR_EN 8'h00
`define IVSF_ADDR_EN_SPARE 8'h01
`define IVSF_ADDR_FLG 8'h02
`define IVSF_ADDR_FLG_SPARE 8'h03

// enable register bits
`define IVSF_BIT_WDT_IE 0
`define IVSF_BIT_OSC_IE 1
`define IVSF_BIT_NMI_IE 4
`define IVSF_BIT_ACCV_IE 5

// flag register bits
`define IVSF_BIT_WDT_FLG 0
`define IVSF_BIT_OSC_FLG 1
`define IVSF_BIT_POR_FLG 2
`define IVSF_BIT_RST_FLG 3
`define IVSF_BIT_NMI_FLG 4

// flag and enable values after power-on and after soft power-up clear
`define IVSF_POR_WDT_FLG 1'b0
`define IVSF_POR_OSC_FLG 1'b1
`define IVSF_POR_POR_FLG 1'b1
`define IVSF_POR_RST_FLG 1'b0
`define IVSF_POR_NMI_FLG 1'b0
`define IVSF_SCLR_OSC_FLG 1'b1
`define IVSF_SCLR_NMI_FLG 1'b0
`define IVSF_SCLR_IE 1'b0

// vector table
`define IVSF_VEC_BASE 16'hFFC0
`define IVSF_VEC_TOP 16'hFFFF
`define IVSF_VEC_RESET 16'hFFFE
`define IVSF_VEC_ERASED 16'hFFFF

// priorities
`define IVSF_PRIO_RESET 5'h1F
`define IVSF_PRIO_NMI 5'h1E
`define IVSF_PRIO_COMP 5'h1B
`define IVSF_PRIO_WDT 5'h1A
`define IVSF_PRIO_TCH0 5'h19
`define IVSF_PRIO_TCH1 5'h18
`define IVSF_PRIO_PORT2 5'h13
`define IVSF_PRIO_PORT1 5'h12
`define IVSF_PRIO_FREE_TOP 5'h0F

// peripheral space end and legal instruction fetch windows
`define IVSF_PERIPH_HI 16'h01FF
`define IVSF_RAM_LO 16'h0200
`define IVSF_RAM_HI 16'h027F
`define IVSF_INFO_LO 16'h1000
`define IVSF_INFO_HI 16'h10FF
`define IVSF_CODE_LO 16'hF800

`endif

// ---- hw/ivsf_pkg.sv ----
package ivsf_pkg;

    typedef enum logic [3:0] {
        ST_BOOT  = 4'h1,
        ST_WAIT  = 4'h2,
        ST_RUN   = 4'h4,
        ST_SLEEP = 4'h8
    } ivsf_state_e;

    typedef logic [4:0] ivsf_prio_t;

endpackage : ivsf_pkg

// ---- hw/ivsf_prio.sv ----
`timescale 1ns/1ps
module ivsf_prio
    import ivsf_pkg::*;
(
    // request per priority level
    input wire logic [31:0] req_in,
    // winner
    output logic valid_out,
    output ivsf_prio_t prio_out
);
    logic [31:0] higher;
    logic [31:0] pick;

    // higher[i] is set when any level above i requests
    assign higher[31] = 1'b0;
    assign pick[31] = req_in[31];
    genvar g;
    generate
        for (g = 0; g < 31; g = g + 1)
        begin : g_lvl
            assign higher[g] = higher[g + 1] | req_in[g + 1];
            assign pick[g] = req_in[g] & ~higher[g];
        end
    endgenerate

    always_comb
    begin
        prio_out = 5'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (pick[i])
            begin
                prio_out = 5'(i);
            end
        end
    end

    assign valid_out = |req_in;
endmodule : ivsf_prio

// ---- hw/ivsf_top.sv ----
// Behaviour
// R1: vectors sit in words FFC0h to FFFFh
// R2: erased reset vector sends device to deepest sleep
// R3: deepest sleep stops cpu, clocks, dc generator, crystal
// R4: all reset causes go through FFFEh, priority 31
// R5: pin event, osc fault, flash violation share FFFCh
// R6: nonmaskable sources obey own enable, ignore global
// R7: comparator at FFF6h priority 27 when fitted
// R8: watchdog interval, timer channels, overflow vectors
// R9: port one flags at FFE4h priority 18
// R10: port two bits 6,7 at FFE6h priority 19
// R11: priorities 15 to 0 carry no source
// R12: fetch from peripherals or unused space resets
// R13: timer, comparator, port flags stay in modules
// R14: unassigned bits absent; 01h, 03h read zero
// R15: enable register bits, cleared by soft clear
// R16: watchdog enable acts only in interval mode
// R17: flag register bits; osc flag set by hardware
// R18: soft clear and power-on preset flag values
// R19: power-on flag set on supply power-up
// R20: external reset flag set by pin reset
// R21: pin nonmaskable flag set in nmi mode
// R22: highest priority first; flags stay until cleared
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "ivsf_cfg.svh"
module ivsf_top
    import ivsf_pkg::*;
#(
    // variant option: comparator fitted
    parameter bit HAS_COMPARATOR = 1'b1
)
(
    // clock and power-on reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // cpu side
    input wire logic gie_in,
    input wire logic fetch_valid_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic soft_powerup_clear_in,
    output logic vec_fetch_req_out,
    input wire logic vec_fetch_valid_in,
    input wire logic [15:0] vec_fetch_data_in,
    output logic irq_req_out,
    output logic [15:0] irq_vector_out,
    output logic [4:0] irq_prio_out,
    output logic reset_req_out,
    // reset / nonmaskable pin
    input wire logic rst_nmi_pin_n_in,
    input wire logic pin_nmi_mode_in,
    // system sources
    input wire logic osc_fault_in,
    input wire logic flash_access_violation_flag_in,
    input wire logic flash_key_violation_flag_in,
    input wire logic wdt_interval_mode_in,
    input wire logic wdt_event_in,
    // module-held flags
    input wire logic comparator_flag_in,
    input wire logic capture_compare_flag0_in,
    input wire logic capture_compare_flag1_in,
    input wire logic timer_overflow_flag_in,
    input wire logic [7:0] port_one_pin_flags_in,
    input wire logic [1:0] port_two_pin_flags_in,
    // power state
    output logic deepest_sleep_mode_out,
    output logic cpu_off_out,
    output logic aclk_off_out,
    output logic mclk_off_out,
    output logic smclk_off_out,
    output logic dc_gen_off_out,
    output logic xtal_stop_out
);
    logic rst_s1_r;
    logic rst_n_r;
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_d_r;
    logic pin_fall;
    logic pin_reset_ev;
    logic pin_nmi_ev;
    logic fetch_bad;
    logic wdt_expire_ev;
    logic soft_clr;
    logic wr_ie;
    logic wr_ifg;
    ivsf_state_e state_r;
    ivsf_state_e state_nxt;
    logic [3:0] sleep_r;
    logic watchdog_interval_enable_r;
    logic osc_fault_enable_r;
    logic pin_nonmaskable_enable_r;
    logic flash_access_violation_enable_r;
    logic watchdog_flag_r;
    logic osc_fault_flag_r;
    logic power_on_flag_r;
    logic external_reset_flag_r;
    logic pin_nonmaskable_flag_r;
    logic [7:0] en_val;
    logic [7:0] flg_val;
    logic [31:0] req;
    logic win_valid;
    ivsf_prio_t win_prio;
    logic nmi_req;

    // reset release through two flops
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // pin synchroniser; first stage read only by second
    always_ff @(posedge clk_sys_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            pin_d_r <= 1'b1;
        end
        else
        begin
            pin_s1_r <= rst_nmi_pin_n_in;
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    assign pin_fall = pin_d_r & ~pin_s2_r;
    assign pin_reset_ev = pin_fall & ~pin_nmi_mode_in;
    assign pin_nmi_ev = pin_fall & pin_nmi_mode_in;
    assign wdt_expire_ev = wdt_event_in & ~wdt_interval_mode_in;

    // only ram, information and code flash may hold instructions
    assign fetch_bad = fetch_valid_in & ~( // [R12]
        ((fetch_addr_in >= `IVSF_RAM_LO) && (fetch_addr_in <= `IVSF_RAM_HI)) ||
        ((fetch_addr_in >= `IVSF_INFO_LO) && (fetch_addr_in <= `IVSF_INFO_HI)) ||
        (fetch_addr_in >= `IVSF_CODE_LO));

    // every reset cause except power-on funnels into one soft clear
    assign soft_clr = soft_powerup_clear_in | pin_reset_ev | wdt_expire_ev | // [R4]
                 flash_key_violation_flag_in | fetch_bad;

    always_ff @(posedge clk_sys_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            reset_req_out <= 1'b0;
        end
        else
        begin
            reset_req_out <= soft_clr & ~soft_powerup_clear_in; // [R4] [R12]
        end
    end

    assign wr_ie = reg_wr_in && (reg_addr_in == `IVSF_ADDR_EN);
    assign wr_ifg = reg_wr_in && (reg_addr_in == `IVSF_ADDR_FLG);

    // enables: cleared by power-on and by soft clear
    always_ff @(posedge clk_sys_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            watchdog_interval_enable_r <= `IVSF_SCLR_IE;
            osc_fault_enable_r <= `IVSF_SCLR_IE;
            pin_nonmaskable_enable_r <= `IVSF_SCLR_IE;
            flash_access_violation_enable_r <= `IVSF_SCLR_IE;
        end
        else if (soft_clr)
        begin
            watchdog_interval_enable_r <= `IVSF_SCLR_IE; // [R15]
            osc_fault_enable_r <= `IVSF_SCLR_IE;
            pin_nonmaskable_enable_r <= `IVSF_SCLR_IE;
            flash_access_violation_enable_r <= `IVSF_SCLR_IE;
        end
        else if (wr_ie)
        begin
            watchdog_interval_enable_r <= reg_wdata_in[`IVSF_BIT_WDT_IE]; // [R15]
            osc_fault_enable_r <= reg_wdata_in[`IVSF_BIT_OSC_IE];
            pin_nonmaskable_enable_r <= reg_wdata_in[`IVSF_BIT_NMI_IE];
            flash_access_violation_enable_r <= reg_wdata_in[`IVSF_BIT_ACCV_IE];
        end
    end

    // flags touched by power-on only; hardware set beats software write
    always_ff @(posedge clk_sys_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            watchdog_flag_r <= `IVSF_POR_WDT_FLG; // [R18]
            power_on_flag_r <= `IVSF_POR_POR_FLG; // [R19]
            external_reset_flag_r <= `IVSF_POR_RST_FLG; // [R20]
        end
        else
        begin
            if (wdt_event_in)
            begin
                watchdog_flag_r <= 1'b1; // [R17]
            end
            else if (wr_ifg)
            begin
                watchdog_flag_r <= reg_wdata_in[`IVSF_BIT_WDT_FLG]; // [R22]
            end
            if (wr_ifg)
            begin
                power_on_flag_r <= reg_wdata_in[`IVSF_BIT_POR_FLG];
            end
            if (pin_reset_ev)
            begin
                external_reset_flag_r <= 1'b1; // [R20]
            end
            else if (wr_ifg)
            begin
                external_reset_flag_r <= reg_wdata_in[`IVSF_BIT_RST_FLG];
            end
        end
    end

    // flags preset by soft clear
    always_ff @(posedge clk_sys_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            osc_fault_flag_r <= `IVSF_POR_OSC_FLG;
            pin_nonmaskable_flag_r <= `IVSF_POR_NMI_FLG;
        end
        else if (soft_clr)
        begin
            osc_fault_flag_r <= `IVSF_SCLR_OSC_FLG; // [R18]
            pin_nonmaskable_flag_r <= `IVSF_SCLR_NMI_FLG;
        end
        else
        begin
            if (osc_fault_in)
            begin
                osc_fault_flag_r <= 1'b1; // [R17]
            end
            else if (wr_ifg)
            begin
                osc_fault_flag_r <= reg_wdata_in[`IVSF_BIT_OSC_FLG];
            end
            if (pin_nmi_ev)
            begin
                pin_nonmaskable_flag_r <= 1'b1; // [R21]
            end
            else if (wr_ifg)
            begin
                pin_nonmaskable_flag_r <= reg_wdata_in[`IVSF_BIT_NMI_FLG];
            end
        end
    end

    // absent bits and the two empty registers read zero
    always_comb
    begin
        en_val = 8'h00; // [R14]
        en_val[`IVSF_BIT_WDT_IE] = watchdog_interval_enable_r;
        en_val[`IVSF_BIT_OSC_IE] = osc_fault_enable_r;
        en_val[`IVSF_BIT_NMI_IE] = pin_nonmaskable_enable_r;
        en_val[`IVSF_BIT_ACCV_IE] = flash_access_violation_enable_r;
        flg_val = 8'h00;
        flg_val[`IVSF_BIT_WDT_FLG] = watchdog_flag_r;
        flg_val[`IVSF_BIT_OSC_FLG] = osc_fault_flag_r;
        flg_val[`IVSF_BIT_POR_FLG] = power_on_flag_r;
        flg_val[`IVSF_BIT_RST_FLG] = external_reset_flag_r;
        flg_val[`IVSF_BIT_NMI_FLG] = pin_nonmaskable_flag_r;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            reg_rdata_out <= 8'h00;
        end
        else if (reg_rd_in && (reg_addr_in == `IVSF_ADDR_EN))
        begin
            reg_rdata_out <= en_val;
        end
        else if (reg_rd_in && (reg_addr_in == `IVSF_ADDR_FLG))
        begin
            reg_rdata_out <= flg_val;
        end
        else
        begin
            reg_rdata_out <= 8'h00; // [R14]
        end
    end

    // boot: read the reset vector once before letting the cpu run
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_BOOT:
            begin
                state_nxt = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (vec_fetch_valid_in)
                begin
                    state_nxt = (vec_fetch_data_in == `IVSF_VEC_ERASED) ? ST_SLEEP : ST_RUN; // [R2]
                end
            end
            ST_RUN:
            begin
                state_nxt = ST_RUN;
            end
            ST_SLEEP:
            begin
                state_nxt = ST_SLEEP;
            end
            default:
            begin
                state_nxt = ST_BOOT;
            end
        endcase
        // a reset restarts the vector check
        if (soft_clr)
        begin
            state_nxt = ST_BOOT;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r <= ST_BOOT;
            vec_fetch_req_out <= 1'b0;
            sleep_r <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            vec_fetch_req_out <= (state_nxt == ST_WAIT) && (state_r == ST_BOOT);
            sleep_r <= {4{state_nxt == ST_SLEEP}};
        end
    end

    // one sleep state gates every clock; a power-on or any soft clear leaves it
    assign deepest_sleep_mode_out = sleep_r[0]; // [R3]
    assign cpu_off_out = sleep_r[0];
    assign aclk_off_out = sleep_r[1];
    assign mclk_off_out = sleep_r[2];
    assign smclk_off_out = sleep_r[2];
    assign dc_gen_off_out = sleep_r[3];
    assign xtal_stop_out = sleep_r[3];

    // request per priority level
    assign nmi_req = (pin_nonmaskable_flag_r & pin_nonmaskable_enable_r) | // [R5] [R6]
                     (osc_fault_flag_r & osc_fault_enable_r) |
                     (flash_access_violation_flag_in & flash_access_violation_enable_r);

    always_comb
    begin
        req = 32'h0000_0000; // [R11]
        req[`IVSF_PRIO_NMI] = nmi_req;
        req[`IVSF_PRIO_COMP] = HAS_COMPARATOR & comparator_flag_in & gie_in; // [R7] [R13]
        req[`IVSF_PRIO_WDT] = watchdog_flag_r & watchdog_interval_enable_r & // [R8] [R16]
                              wdt_interval_mode_in & gie_in;
        req[`IVSF_PRIO_TCH0] = capture_compare_flag0_in & gie_in; // [R8]
        req[`IVSF_PRIO_TCH1] = (capture_compare_flag1_in | timer_overflow_flag_in) & gie_in;
        req[`IVSF_PRIO_PORT2] = (|port_two_pin_flags_in) & gie_in; // [R10]
        req[`IVSF_PRIO_PORT1] = (|port_one_pin_flags_in) & gie_in; // [R9]
    end

    ivsf_prio u_prio
    (
        .req_in(req),
        .valid_out(win_valid),
        .prio_out(win_prio)
    );

    always_ff @(posedge clk_sys_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            irq_req_out <= 1'b0;
            irq_prio_out <= 5'h00;
            irq_vector_out <= `IVSF_VEC_RESET;
        end
        else
        begin
            irq_req_out <= win_valid && (state_r == ST_RUN) && !soft_clr; // [R22]
            irq_prio_out <= win_prio;
            irq_vector_out <= `IVSF_VEC_BASE | {10'h000, win_prio, 1'b0}; // [R1]
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_r);

    sequence seq_boot_erased;
        (state_r == ST_WAIT) && vec_fetch_valid_in && (vec_fetch_data_in == `IVSF_VEC_ERASED) && !soft_clr;
    endsequence

    sequence seq_sleep_held;
        (state_r == ST_SLEEP) && sleep_r[0] && xtal_stop_out && aclk_off_out;
    endsequence

    chk_vec_range: assert property (irq_req_out |-> (irq_vector_out >= `IVSF_VEC_BASE) && !irq_vector_out[0]) // [R1]
        else $error("vector outside table");
    chk_erased_sleep: assert property (seq_boot_erased |=> seq_sleep_held) // [R2]
        else $error("erased reset vector did not sleep");
    chk_sleep_clocks: assert property ((state_r == ST_SLEEP) |-> cpu_off_out && mclk_off_out && smclk_off_out && dc_gen_off_out) // [R3]
        else $error("clocks running in deepest sleep");
    chk_fetch_reset: assert property (fetch_bad && !soft_powerup_clear_in |=> reset_req_out && (state_r == ST_BOOT)) // [R12]
        else $error("illegal fetch did not reset");
    chk_nmi_no_gie: assert property ((state_r == ST_RUN) && !soft_clr && !gie_in && pin_nonmaskable_flag_r && pin_nonmaskable_enable_r |=> irq_req_out && (irq_prio_out == `IVSF_PRIO_NMI)) // [R6]
        else $error("nonmaskable request blocked by global enable");
    chk_no_low_prio: assert property (irq_req_out |-> (irq_prio_out > `IVSF_PRIO_FREE_TOP)) // [R11]
        else $error("request on unused vector");
    chk_comp_absent: assert property (!HAS_COMPARATOR && irq_req_out |-> (irq_prio_out != `IVSF_PRIO_COMP)) // [R7]
        else $error("comparator vector without comparator");
    chk_clear_preset: assert property (soft_clr |=> (en_val == 8'h00) && osc_fault_flag_r && !pin_nonmaskable_flag_r) // [R15] [R18]
        else $error("soft clear presets wrong");
    chk_wdt_mode: assert property (!wdt_interval_mode_in |-> !req[`IVSF_PRIO_WDT]) // [R16]
        else $error("watchdog enable active in watchdog mode");
    chk_osc_sticky: assert property ($fell(osc_fault_flag_r) |-> $past(wr_ifg) && !$past(reg_wdata_in[`IVSF_BIT_OSC_FLG])) // [R22]
        else $error("oscillator flag dropped without software clear");
    chk_pin_ext_flag: assert property (pin_reset_ev |=> external_reset_flag_r && reset_req_out) // [R20]
        else $error("pin reset not recorded");
endmodule : ivsf_top

// ---- test/ivsf_cpu_model.sv ----
`timescale 1ns/1ps
module ivsf_cpu_model
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // vector word request from the block; boot word and latency from the bench
    input wire logic vec_fetch_req_in,
    input wire logic [15:0] boot_word_in,
    input wire logic [3:0] latency_in,
    // answer
    output logic vec_fetch_valid_out,
    output logic [15:0] vec_fetch_data_out
);
    logic busy_r;
    logic [3:0] wait_r;
    logic [15:0] last_r;

    // memory answers after a chosen number of cycles, so prompt and slow flash both occur
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            busy_r <= 1'b0;
            wait_r <= 4'h0;
            last_r <= 16'h0000;
            vec_fetch_valid_out <= 1'b0;
            vec_fetch_data_out <= 16'h0000;
        end
        else
        begin
            vec_fetch_valid_out <= 1'b0;
            // between answers the bus shows no stale word
            vec_fetch_data_out <= ~last_r;
            if (vec_fetch_req_in)
            begin
                busy_r <= 1'b1;
                wait_r <= latency_in;
            end
            else if (busy_r && wait_r != 4'h0)
                wait_r <= wait_r - 4'h1;
            else if (busy_r)
            begin
                busy_r <= 1'b0;
                vec_fetch_valid_out <= 1'b1;
                vec_fetch_data_out <= boot_word_in;
                last_r <= boot_word_in;
            end
        end
    end
endmodule : ivsf_cpu_model

// ---- test/ivsf_top_tb_top.sv ----
`timescale 1ns/1ps
module ivsf_top_tb_top;
    logic clk, rst_n, reg_wr, reg_rd, gie, fv, spc, pin_n, pin_mode, osc, accv, kvio;
    logic wdt_int, wdt_ev, cmp, cc0, cc1, ovf, vvalid, irq, vreq, rreq;
    logic [7:0] addr, wdata, rdata, p1;
    logic [1:0] p2;
    logic [15:0] faddr, vdata, vec, bootw;
    logic [4:0] prio;
    logic [6:0] pwr;
    logic [3:0] lat;
    int failures, compares, rst_cnt, vec_cnt;

    ivsf_top dut (.clk_sys_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .gie_in(gie), .fetch_valid_in(fv), .fetch_addr_in(faddr),
        .soft_powerup_clear_in(spc), .vec_fetch_req_out(vreq), .vec_fetch_valid_in(vvalid),
        .vec_fetch_data_in(vdata), .irq_req_out(irq), .irq_vector_out(vec),
        .irq_prio_out(prio), .reset_req_out(rreq), .rst_nmi_pin_n_in(pin_n),
        .pin_nmi_mode_in(pin_mode), .osc_fault_in(osc), .flash_access_violation_flag_in(accv),
        .flash_key_violation_flag_in(kvio), .wdt_interval_mode_in(wdt_int),
        .wdt_event_in(wdt_ev), .comparator_flag_in(cmp), .capture_compare_flag0_in(cc0),
        .capture_compare_flag1_in(cc1), .timer_overflow_flag_in(ovf),
        .port_one_pin_flags_in(p1), .port_two_pin_flags_in(p2),
        .deepest_sleep_mode_out(pwr[6]), .cpu_off_out(pwr[5]), .aclk_off_out(pwr[4]),
        .mclk_off_out(pwr[3]), .smclk_off_out(pwr[2]), .dc_gen_off_out(pwr[1]),
        .xtal_stop_out(pwr[0]));

    ivsf_cpu_model cpu (.clk_sys_in(clk), .rst_n_in(rst_n), .vec_fetch_req_in(vreq),
        .boot_word_in(bootw), .latency_in(lat), .vec_fetch_valid_out(vvalid),
        .vec_fetch_data_out(vdata));

    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        if (rreq === 1'b1)
            rst_cnt++;
        if (vreq === 1'b1)
            vec_cnt++;
    end

    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: register data %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_irq(input logic r, input logic [4:0] p);
        compares++;
        if (irq !== r || (r && (prio !== p || vec !== 16'hFFC0 + {10'h000, p, 1'b0})))
        begin
            failures++;
            $display("wrong value at %0t: request %b level %0d expected %b %0d", $time, irq,
                prio, r, p);
        end
    endtask : chk_irq

    task automatic chk_pwr(input logic [6:0] exp);
        compares++;
        if (pwr !== exp)
        begin
            failures++;
            $display("wrong value at %0t: power outputs %b expected %b", $time, pwr, exp);
        end
    endtask : chk_pwr

    task automatic chk_cnt(input int got, input int exp);
        compares++;
        if (got != exp)
        begin
            failures++;
            $display("wrong value at %0t: pulse count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk_reg(rdata, exp);
    endtask : rd_reg

    // one cause held for one cycle (the pin for four), then time to reboot
    task automatic kick(input int k, input logic [15:0] fa);
        @(posedge clk);
        case (k)
            0: fv <= 1'b1;
            1: kvio <= 1'b1;
            2: wdt_ev <= 1'b1;
            3: pin_n <= 1'b0;
            default: spc <= 1'b1;
        endcase
        faddr <= fa;
        @(posedge clk);
        fv <= 1'b0;
        kvio <= 1'b0;
        wdt_ev <= 1'b0;
        spc <= 1'b0;
        repeat (3) @(posedge clk);
        pin_n <= 1'b1;
        cyc(16);
    endtask : kick

    task automatic t_reset_values();
        rd_reg(8'h00, 8'h00);
        rd_reg(8'h01, 8'h00);
        rd_reg(8'h02, 8'h06);
        rd_reg(8'h03, 8'h00);
        chk_irq(1'b0, 5'h00);
        chk_pwr(7'h00);
    endtask : t_reset_values

    task automatic t_registers();
        wr_reg(8'h00, 8'hFF);
        rd_reg(8'h00, 8'h33);
        wr_reg(8'h00, 8'h00);
        wr_reg(8'h01, 8'hFF);
        rd_reg(8'h01, 8'h00);
        wr_reg(8'h02, 8'hFF);
        rd_reg(8'h02, 8'h1F);
        wr_reg(8'h03, 8'hFF);
        rd_reg(8'h03, 8'h00);
        wr_reg(8'h02, 8'h00);
        rd_reg(8'h02, 8'h00);
    endtask : t_registers

    task automatic t_resets();
        int n;
        int v;
        n = rst_cnt;
        v = vec_cnt;
        lat <= 4'h5;
        wr_reg(8'h00, 8'h33);
        kick(0, 16'h0250);
        chk_cnt(rst_cnt, n);
        rd_reg(8'h00, 8'h33);
        kick(0, 16'h0100);
        chk_cnt(rst_cnt, n + 1);
        rd_reg(8'h00, 8'h00);
        rd_reg(8'h02, 8'h02);
        kick(0, 16'h2000);
        kick(1, 16'h0000);
        chk_cnt(rst_cnt, n + 3);
        kick(2, 16'h0000);
        chk_cnt(rst_cnt, n + 4);
        rd_reg(8'h02, 8'h03);
        kick(3, 16'h0000);
        chk_cnt(rst_cnt, n + 5);
        rd_reg(8'h02, 8'h0B);
        wr_reg(8'h00, 8'h33);
        kick(4, 16'h0000);
        chk_cnt(rst_cnt, n + 5);
        chk_cnt(vec_cnt, v + 6);
        rd_reg(8'h00, 8'h00);
        rd_reg(8'h02, 8'h0B);
        lat <= 4'h0;
    endtask : t_resets

    task automatic t_nonmaskable();
        wr_reg(8'h02, 8'h00);
        wr_reg(8'h00, 8'h02);
        cyc(3);
        chk_irq(1'b0, 5'h00);
        @(posedge clk);
        osc <= 1'b1;
        @(posedge clk);
        osc <= 1'b0;
        cyc(3);
        chk_irq(1'b1, 5'h1E);
        rd_reg(8'h02, 8'h02);
        wr_reg(8'h02, 8'h00);
        cyc(3);
        chk_irq(1'b0, 5'h00);
        accv <= 1'b1;
        wr_reg(8'h00, 8'h20);
        cyc(3);
        chk_irq(1'b1, 5'h1E);
        wr_reg(8'h00, 8'h00);
        cyc(3);
        chk_irq(1'b0, 5'h00);
        accv <= 1'b0;
        pin_mode <= 1'b1;
        kick(3, 16'h0000);
        rd_reg(8'h02, 8'h10);
        wr_reg(8'h00, 8'h10);
        cyc(3);
        chk_irq(1'b1, 5'h1E);
        wr_reg(8'h00, 8'h00);
        wr_reg(8'h02, 8'h00);
    endtask : t_nonmaskable

    task automatic t_priority();
        logic [4:0] exp [6] = '{5'h1B, 5'h1A, 5'h19, 5'h18, 5'h13, 5'h12};
        @(posedge clk);
        wdt_int <= 1'b1;
        wdt_ev <= 1'b1;
        @(posedge clk);
        wdt_ev <= 1'b0;
        wr_reg(8'h00, 8'h01);
        gie <= 1'b1;
        cmp <= 1'b1;
        cc0 <= 1'b1;
        cc1 <= 1'b1;
        p1 <= 8'h80;
        p2 <= 2'b10;
        cyc(3);
        for (int i = 0; i < 6; i++)
        begin
            chk_irq(1'b1, exp[i]);
            @(posedge clk);
            case (i)
                0: cmp <= 1'b0;
                1: wdt_int <= 1'b0;
                2: cc0 <= 1'b0;
                3: cc1 <= 1'b0;
                4: p2 <= 2'b00;
                default: p1 <= 8'h00;
            endcase
            cyc(3);
        end
        chk_irq(1'b0, 5'h00);
        ovf <= 1'b1;
        cyc(3);
        chk_irq(1'b1, 5'h18);
        gie <= 1'b0;
        cyc(3);
        chk_irq(1'b0, 5'h00);
        wr_reg(8'h02, 8'h00);
    endtask : t_priority

    task automatic t_sleep();
        chk_pwr(7'h00);
        bootw <= 16'hFFFF;
        gie <= 1'b1;
        kick(4, 16'h0000);
        chk_pwr(7'h7F);
        chk_irq(1'b0, 5'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        bootw <= 16'hF800;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        cyc(16);
        chk_pwr(7'h00);
        chk_irq(1'b1, 5'h18);
        rd_reg(8'h02, 8'h06);
    endtask : t_sleep

    initial
    begin
        {clk, rst_n, reg_wr, reg_rd, gie, fv, spc, pin_mode, osc, accv, kvio} = '0;
        {wdt_int, wdt_ev, cmp, cc0, cc1, ovf, addr, wdata, p1, p2, faddr} = '0;
        pin_n = 1'b1;
        bootw = 16'hF800;
        lat = 4'h2;
        failures = 0;
        compares = 0;
        rst_cnt = 0;
        vec_cnt = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        cyc(16);
        chk_cnt(vec_cnt, 1);
        t_reset_values();
        t_registers();
        t_resets();
        t_nonmaskable();
        t_priority();
        t_sleep();
        final_report();
    end

    initial
    begin
        #200000;
        failures++;
        $display("wrong value at %0t: run did not finish in time", $time);
        final_report();
    end
endmodule : ivsf_top_tb_top
